// ---- fetch_pipeline_memory_map_tb_top.sv ----
// self-checking bench for the fetch pipeline and banked data memory
`timescale 1ns/1ps
`include "fpm_cfg.svh"

module fetch_pipeline_memory_map_tb_top
    import fpm_pkg::*;
;
    localparam int PAW = 11;

    logic                   clk_in;
    logic                   reset_n_in;
    logic [PAW-1:0]         prog_addr;
    logic [`FPM_INSN_W-1:0] prog_data;
    logic [3:0]             phase;
    logic [`FPM_INSN_W-1:0] insn;
    logic                   exec_valid;
    logic [7:0]             operand;
    logic [7:0]             status;
    logic [7:0]             result;
    logic                   result_we;
    logic                   branch;
    logic [`FPM_PC_W-1:0]   branch_tgt;
    logic                   int_req;
    logic                   int_accept;
    logic [`FPM_PC_W-1:0]   return_pc;
    logic [7:0]             addr;
    logic [7:0]             wr_data;
    logic                   wr_stb;
    logic                   rd_stb;
    logic [7:0]             rd_data;
    int                     num_errors;
    int                     n_checks;

    fpm_core #(.PROG_AW(PAW), .LARGE(1'b1)) uut (
        .CLK_IN(clk_in), .RESET_N_IN(reset_n_in),
        .PROG_ADDR_OUT(prog_addr), .PROG_DATA_IN(prog_data),
        .PHASE_OUT(phase), .INSN_OUT(insn), .EXEC_VALID_OUT(exec_valid),
        .OPERAND_OUT(operand), .STATUS_OUT(status), .RESULT_IN(result),
        .RESULT_WE_IN(result_we), .BRANCH_IN(branch),
        .BRANCH_TARGET_IN(branch_tgt), .INT_REQ_IN(int_req),
        .INT_ACCEPT_OUT(int_accept), .RETURN_PC_OUT(return_pc),
        .ADDR_IN(addr), .WR_DATA_IN(wr_data), .WR_STB_IN(wr_stb),
        .RD_STB_IN(rd_stb), .RD_DATA_OUT(rd_data)
    );

    // word at 008h jumps to 100h, every other word carries its own address
    function automatic logic [13:0] rom(input logic [PAW-1:0] a);
        rom = (a == 11'h008) ? {`FPM_JUMP_OPC, 11'h100} : {3'h0, a};
    endfunction : rom

    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) prog_data <= rom(prog_addr);

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, what, got, exp);
            num_errors++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clk_in);
        wr_stb  <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk_in);
        rd_stb <= 1'b0;
        #1;
        chk({8'h00, rd_data}, {8'h00, exp}, "register read");
    endtask : rdc

    task automatic wait_ph(input int b);
        int k;
        k = 0;
        do begin
            @(posedge clk_in);
            #1;
            k++;
        end while (phase[b] !== 1'b1 && k < 8);
    endtask : wait_ph

    task automatic wait_exec();
        int k;
        k = 0;
        do begin
            wait_ph(2);
            k++;
        end while (exec_valid !== 1'b1 && k < 4);
    endtask : wait_exec

    // called in phase three, so the drive covers exactly phase four
    task automatic drive_ph4(input logic br, input logic [12:0] tgt,
                             input logic we, input logic [7:0] res);
        @(posedge clk_in);
        branch     <= br;
        branch_tgt <= tgt;
        result_we  <= we;
        result     <= res;
        @(posedge clk_in);
        branch     <= 1'b0;
        result_we  <= 1'b0;
    endtask : drive_ph4

    task automatic do_reset();
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
    endtask : do_reset

    initial begin
        #100000;
        num_errors++;
        $display("watchdog expired at %0t", $time);
        print_verdict();
    end

    initial begin
        logic [7:0]  ga [6] = '{8'h20, 8'h6F, 8'h70, 8'h7F, 8'hA0, 8'hBF};
        logic [7:0]  ua [6] = '{8'h01, 8'h09, 8'h1F, 8'h8C, 8'hC0, 8'hFF};
        logic [7:0]  ra [4] = '{8'h03, 8'h04, 8'h0A, 8'h0B};
        logic [10:0] ea;
        logic [10:0] fa;
        int          k;
        {clk_in, reset_n_in, result, result_we, branch} = '0;
        {branch_tgt, int_req, addr, wr_data, wr_stb, rd_stb} = '0;
        num_errors = 0;
        n_checks = 0;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
        chk({5'h0, prog_addr}, 16'h0000, "reset fetch address");
        chk({15'h0, exec_valid}, 16'h0000, "reset exec valid");
        for (k = 0; k < 9; k++) begin
            chk({12'h0, phase}, 16'(4'h1 << (k % 4)), "phase");
            @(posedge clk_in);
            #1;
        end
        $display("test phases done");
        // second reset in mid-run, then trace one jump through the pipe
        do_reset();
        for (k = 1; k <= 13; k++) begin
            wait_ph(2);
            ea = (k <= 10) ? 11'(k - 2) : 11'(32'h100 + k - 12);
            fa = (k <= 10) ? 11'(k - 1) : 11'(32'h100 + k - 11);
            if (k == 1 || k == 11) begin
                chk({15'h0, exec_valid}, 16'h0000, "flushed slot");
            end else begin
                chk({15'h0, exec_valid}, 16'h0001, "exec valid");
                chk({2'h0, insn}, {2'h0, rom(ea)}, "executed word");
            end
            chk({5'h0, prog_addr}, {5'h0, fa}, "fetch address");
        end
        $display("test pipeline done");
        foreach (ra[i]) rdc(ra[i], 8'h00);
        foreach (ga[i]) wr(ga[i], ga[i] ^ 8'h5A);
        foreach (ga[i]) rdc(ga[i], ga[i] ^ 8'h5A);
        wr(8'h40, 8'h11);
        foreach (ua[i]) wr(ua[i], 8'hFF);
        foreach (ua[i]) rdc(ua[i], 8'h00);
        rdc(8'h40, 8'h11);
        wr(8'h8A, 8'h15);
        rdc(8'h0A, 8'h15);
        wr(8'h0A, 8'h00);
        wr(8'h84, 8'hA7);
        wr(8'h00, 8'h66);
        rdc(8'hA7, 8'h66);
        rdc(8'h80, 8'h66);
        rdc(8'h04, 8'hA7);
        wr(8'hA7, 8'h99);
        rdc(8'h00, 8'h99);
        wr(8'h04, 8'h00);
        rdc(8'h00, 8'h00);
        $display("test data map done");
        wr(8'h25, 8'h5A);
        wr(8'hA5, 8'hA5);
        wait_exec();
        drive_ph4(1'b1, 13'h0025, 1'b0, 8'h00);
        wait_exec();
        chk({2'h0, insn}, {2'h0, rom(11'h025)}, "branch target");
        chk({8'h0, operand}, 16'h005A, "bank zero operand");
        drive_ph4(1'b0, 13'h0000, 1'b1, 8'h3C);
        rdc(8'h25, 8'h3C);
        wr(8'h83, 8'h20);
        #1;
        chk({8'h0, status}, 16'h0020, "bank select");
        wait_exec();
        drive_ph4(1'b1, 13'h0025, 1'b0, 8'h00);
        wait_exec();
        chk({8'h0, operand}, 16'h00A5, "bank one operand");
        wr(8'h03, 8'h00);
        $display("test operands done");
        wait_exec();
        drive_ph4(1'b1, 13'h1FFF, 1'b0, 8'h00);
        wait_ph(2);
        chk({5'h0, prog_addr}, 16'h07FF, "wrapped fetch");
        wait_exec();
        chk({2'h0, insn}, {2'h0, rom(11'h7FF)}, "wrapped word");
        chk({5'h0, prog_addr}, 16'h0000, "wrap to zero");
        $display("test wrap done");
        wr(8'h0B, 8'h80);
        @(posedge clk_in);
        int_req <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_in);
            #1;
            k++;
        end while (int_accept !== 1'b1 && k < 40);
        chk({15'h0, int_accept}, 16'h0001, "interrupt accepted");
        chk({3'h0, return_pc}, {5'h0, insn[10:0] + 11'h1}, "return pc");
        @(posedge clk_in);
        int_req <= 1'b0;
        wait_exec();
        chk({2'h0, insn}, {2'h0, rom(11'h004)}, "interrupt vector");
        rdc(8'h0B, 8'h00);
        wr(8'h0A, 8'h01);
        wait_exec();
        wr(8'h82, 8'h40);
        wait_exec();
        chk({2'h0, insn}, {2'h0, rom(11'h140)}, "pc low write");
        $display("test interrupt done");
        print_verdict();
    end
endmodule : fetch_pipeline_memory_map_tb_top

// ---- fpm_cfg.svh ----
// constants for the fetch pipeline and data memory map
`ifndef FPM_CFG_SVH
`define FPM_CFG_SVH
`define FPM_PC_W          13
`define FPM_INSN_W        14
`define FPM_RESET_VEC     13'h0000
`define FPM_INT_VEC       13'h0004
`define FPM_ADDR_INDIRECT 7'h00
`define FPM_ADDR_PCL      7'h02
`define FPM_ADDR_STATUS   7'h03
`define FPM_ADDR_FSR      7'h04
`define FPM_ADDR_PC_HIGH_LATCH   7'h0A
`define FPM_ADDR_INTCTL   7'h0B
`define FPM_SFR_LIMIT     7'h20
`define FPM_B0_LAST_SMALL 7'h6F
`define FPM_B0_LAST_LARGE 7'h7F
`define FPM_B1_LAST       7'h3F
`define FPM_B1_BASE       7'h60
`define FPM_BANK_BIT      5
`define FPM_GIE_BIT       7
`define FPM_OPC_HI        13
`define FPM_OPC_LO        11
`define FPM_JUMP_OPC      3'h6
`define FPM_LATCH_HI      4
`define FPM_LATCH_LO      3
`define FPM_STATUS_RST    8'h00
`define FPM_FSR_RST       8'h00
`define FPM_PC_HIGH_LATCH_RST    8'h00
`define FPM_INTCTL_RST    8'h00
`define FPM_GPR_SMALL     80
`define FPM_GPR_LARGE     128
`define FPM_PROG_AW       11
`endif

// ---- fpm_core.sv ----
// instruction fetch pipeline, program counter and banked data memory
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "fpm_cfg.svh"

module fpm_core
    import fpm_pkg::*;
#(
    parameter int PROG_AW = `FPM_PROG_AW,
    parameter bit LARGE   = 1'b1
) (
    // clock and reset
    input  wire logic                   CLK_IN,
    input  wire logic                   RESET_N_IN,
    // program memory
    output logic [PROG_AW-1:0]          PROG_ADDR_OUT,
    input  wire logic [`FPM_INSN_W-1:0] PROG_DATA_IN,
    // execution unit side
    output logic [3:0]                  PHASE_OUT,
    output logic [`FPM_INSN_W-1:0]      INSN_OUT,
    output logic                        EXEC_VALID_OUT,
    output logic [7:0]                  OPERAND_OUT,
    output logic [7:0]                  STATUS_OUT,
    input  wire logic [7:0]             RESULT_IN,
    input  wire logic                   RESULT_WE_IN,
    input  wire logic                   BRANCH_IN,
    input  wire logic [`FPM_PC_W-1:0]   BRANCH_TARGET_IN,
    // interrupt request and acceptance
    input  wire logic                   INT_REQ_IN,
    output logic                        INT_ACCEPT_OUT,
    output logic [`FPM_PC_W-1:0]        RETURN_PC_OUT,
    // register port
    input  wire logic [7:0]             ADDR_IN,
    input  wire logic [7:0]             WR_DATA_IN,
    input  wire logic                   WR_STB_IN,
    input  wire logic                   RD_STB_IN,
    output logic [7:0]                  RD_DATA_OUT
);
    localparam int GPR_DEPTH = LARGE ? `FPM_GPR_LARGE : `FPM_GPR_SMALL;
    localparam logic [6:0] B0_LAST =
        LARGE ? `FPM_B0_LAST_LARGE : `FPM_B0_LAST_SMALL;

    fpm_phase_e            phase_reg;
    fpm_phase_e            phase_next;
    logic [`FPM_PC_W-1:0]  pc_reg;
    logic [`FPM_PC_W-1:0]  pc_next;
    logic [`FPM_PC_W-1:0]  fetch_addr_reg;
    logic [`FPM_INSN_W-1:0] fetch_word_reg;
    logic [`FPM_INSN_W-1:0] insn_reg;
    logic                  exec_valid_reg;
    logic                  flush_reg;
    logic                  flush_next;
    logic [7:0]            status_reg;
    logic [7:0]            fsr_reg;
    logic [7:0]            pc_high_latch_reg;
    logic [7:0]            intctl_reg;
    logic [7:0]            operand_reg;
    logic [7:0]            rd_data_reg;
    logic                  int_accept_reg;
    logic [`FPM_PC_W-1:0]  return_pc_reg;
    logic [7:0]            gpr_mem [GPR_DEPTH];

    // port 0 is the execution unit, port 1 the register port
    logic [7:0]            raw_addr [2];
    logic [7:0]            wdata    [2];
    logic                  we       [2];
    fpm_dm_sel_s           sel      [2];
    logic [7:0]            rdata    [2];

    wire ph_one  = (phase_reg == PH_ONE);
    wire ph_two  = (phase_reg == PH_TWO);
    wire ph_four = (phase_reg == PH_FOUR);

    // address resolution shared by both ports
    function automatic fpm_dm_sel_s map_sel(input logic [7:0] raw,
                                            input logic [7:0] ptr);
        logic [7:0]  a;
        logic [6:0]  lo;
        fpm_dm_sel_s s;
        a = (raw[6:0] == `FPM_ADDR_INDIRECT) ? ptr : raw;
        lo = a[6:0];
        s.kind = DM_NONE;
        s.idx = 7'h00;
        // bank bit ignored for shared core registers
        if (lo == `FPM_ADDR_PCL) begin
            s.kind = DM_PCL;
        end else if (lo == `FPM_ADDR_STATUS) begin
            s.kind = DM_STATUS;
        end else if (lo == `FPM_ADDR_FSR) begin
            s.kind = DM_FSR;
        end else if (lo == `FPM_ADDR_PC_HIGH_LATCH) begin
            s.kind = DM_PC_HIGH_LATCH;
        end else if (lo == `FPM_ADDR_INTCTL) begin
            s.kind = DM_INTCTL;
        end else if (lo < `FPM_SFR_LIMIT) begin
            // pointer at itself and peripheral slots hold nothing here
            s.kind = DM_NONE;
        end else if (!a[7] && lo <= B0_LAST) begin
            s.kind = DM_GPR;
            s.idx = lo - `FPM_SFR_LIMIT;
        end else if (a[7] && LARGE && lo <= `FPM_B1_LAST) begin
            s.kind = DM_GPR;
            s.idx = lo - `FPM_SFR_LIMIT + `FPM_B1_BASE;
        end
        return s;
    endfunction : map_sel

    // direct address of the executing word, bank from status
    assign raw_addr[0] = {status_reg[`FPM_BANK_BIT], insn_reg[6:0]};
    assign raw_addr[1] = ADDR_IN;
    assign wdata[0]    = RESULT_IN;
    assign wdata[1]    = WR_DATA_IN;
    assign we[0]       = ph_four && exec_valid_reg && RESULT_WE_IN;
    assign we[1]       = WR_STB_IN;

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_port
            assign sel[gp] = map_sel(raw_addr[gp], fsr_reg);
            assign rdata[gp] =
                (sel[gp].kind == DM_PCL)    ? pc_reg[7:0] :
                (sel[gp].kind == DM_STATUS) ? status_reg :
                (sel[gp].kind == DM_FSR)    ? fsr_reg :
                (sel[gp].kind == DM_PC_HIGH_LATCH) ? pc_high_latch_reg :
                (sel[gp].kind == DM_INTCTL) ? intctl_reg :
                (sel[gp].kind == DM_GPR)    ? gpr_mem[sel[gp].idx] :
                8'h00;
        end
    endgenerate

    // program counter loads
    wire pcl_wr0 = we[0] && (sel[0].kind == DM_PCL);
    wire pcl_wr1 = we[1] && (sel[1].kind == DM_PCL);
    wire pcl_load = pcl_wr0 || pcl_wr1;
    wire [7:0] pcl_val = pcl_wr1 ? WR_DATA_IN : RESULT_IN;
    wire [`FPM_PC_W-1:0] pcl_target = {pc_high_latch_reg[4:0], pcl_val};

    wire jump_dec = (insn_reg[`FPM_OPC_HI:`FPM_OPC_LO] == `FPM_JUMP_OPC);
    wire [`FPM_PC_W-1:0] jump_target =
        {pc_high_latch_reg[`FPM_LATCH_HI:`FPM_LATCH_LO], insn_reg[10:0]};
    wire exec_q4    = ph_four && exec_valid_reg;
    wire jump_take  = exec_q4 && jump_dec;
    wire ext_take   = exec_q4 && !jump_dec && BRANCH_IN;
    wire branch_any = jump_take || ext_take || pcl_load;
    wire int_take   = exec_q4 && !branch_any && INT_REQ_IN
                      && intctl_reg[`FPM_GIE_BIT];

    always_comb begin
        phase_next = fpm_phase_e'(phase_reg + 2'h1);
        pc_next = pc_reg;
        if (ph_one) begin
            pc_next = pc_reg + 13'h0001;
        end
        if (pcl_load) begin
            pc_next = pcl_target;
        end else if (jump_take) begin
            pc_next = jump_target;
        end else if (ext_take) begin
            pc_next = BRANCH_TARGET_IN;
        end else if (int_take) begin
            pc_next = `FPM_INT_VEC;
        end
        // a new flush wins over consuming the old one
        flush_next = flush_reg;
        if (ph_one) begin
            flush_next = 1'b0;
        end
        if (branch_any || int_take) begin
            flush_next = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            phase_reg <= PH_ONE;
            pc_reg <= `FPM_RESET_VEC;
            fetch_addr_reg <= `FPM_RESET_VEC;
            flush_reg <= 1'b1;
        end else begin
            phase_reg <= phase_next;
            pc_reg <= pc_next;
            flush_reg <= flush_next;
            if (ph_one) begin
                fetch_addr_reg <= pc_reg;
            end
        end
    end

    // fetched word taken at phase four, latched for execution at phase one
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            fetch_word_reg <= '0;
            insn_reg <= '0;
            exec_valid_reg <= 1'b0;
        end else begin
            if (ph_four) begin
                fetch_word_reg <= PROG_DATA_IN;
            end
            if (ph_one) begin
                insn_reg <= fetch_word_reg;
                exec_valid_reg <= !flush_reg;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            operand_reg <= 8'h00;
        end else if (ph_two && exec_valid_reg) begin
            operand_reg <= rdata[0];
        end
    end

    // core registers; register port write is applied after the core's
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            status_reg <= `FPM_STATUS_RST;
            fsr_reg <= `FPM_FSR_RST;
            pc_high_latch_reg <= `FPM_PC_HIGH_LATCH_RST;
            intctl_reg <= `FPM_INTCTL_RST;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (we[p]) begin
                    case (sel[p].kind)
                        DM_STATUS: status_reg <= wdata[p];
                        DM_FSR:    fsr_reg <= wdata[p];
                        DM_PC_HIGH_LATCH: pc_high_latch_reg <= wdata[p];
                        DM_INTCTL: intctl_reg <= wdata[p];
                        default:   ;
                    endcase
                end
            end
            // entering the handler masks further requests
            if (int_take) begin
                intctl_reg[`FPM_GIE_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        for (int p = 0; p < 2; p++) begin
            if (we[p] && sel[p].kind == DM_GPR) begin
                gpr_mem[sel[p].idx] <= wdata[p];
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            rd_data_reg <= 8'h00;
            int_accept_reg <= 1'b0;
            return_pc_reg <= `FPM_RESET_VEC;
        end else begin
            rd_data_reg <= RD_STB_IN ? rdata[1] : 8'h00;
            int_accept_reg <= int_take;
            if (int_take) begin
                // the discarded fetch is where the handler returns to
                return_pc_reg <= fetch_addr_reg;
            end
        end
    end

    // high address bits dropped so accesses wrap into implemented space
    assign PROG_ADDR_OUT  = fetch_addr_reg[PROG_AW-1:0];
    assign PHASE_OUT      = 4'h1 << phase_reg;
    assign INSN_OUT       = insn_reg;
    assign EXEC_VALID_OUT = exec_valid_reg;
    assign OPERAND_OUT    = operand_reg;
    assign STATUS_OUT     = status_reg;
    assign INT_ACCEPT_OUT = int_accept_reg;
    assign RETURN_PC_OUT  = return_pc_reg;
    assign RD_DATA_OUT    = rd_data_reg;

    AST_PHASE_SEQ: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        ph_one |=> ph_two ##1 (phase_reg == PH_THREE) ##1 ph_four ##1 ph_one)
        else $error("phase order broken");

    AST_PHASE_DIV: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        PHASE_OUT[0] |=> !PHASE_OUT[0] [*3] ##1 PHASE_OUT[0])
        else $error("phase one not every fourth clock");

    AST_PC_INC: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        (ph_one && !pcl_load) |=> pc_reg == $past(pc_reg) + 13'h0001)
        else $error("pc did not increment in phase one");

    AST_THROUGHPUT: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        (ph_four && !branch_any && !int_take && !flush_reg) ##1 !pcl_load
        |=> exec_valid_reg)
        else $error("next instruction not executed");

    AST_FLUSH: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        (ph_four && branch_any) |=> ##1 !exec_valid_reg [*4])
        else $error("fetched word not discarded on branch");

    AST_JUMP_TARGET: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        (jump_take && !pcl_load) |=> ##1
        fetch_addr_reg == $past(jump_target, 2))
        else $error("jump target not fetched next cycle");

    AST_RESET_VEC: assert property (@(posedge CLK_IN)
        !RESET_N_IN |=> (pc_reg == `FPM_RESET_VEC) && ph_one)
        else $error("reset vector not loaded");

    AST_INT_VEC: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        int_take |=> (pc_reg == `FPM_INT_VEC) && INT_ACCEPT_OUT)
        else $error("interrupt vector not loaded");

    AST_UNIMPL_ZERO: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        (RD_STB_IN && sel[1].kind == DM_NONE) |=> RD_DATA_OUT == 8'h00)
        else $error("unimplemented address read nonzero");

    AST_OPERAND_Q2: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        $changed(operand_reg) |-> $past(ph_two))
        else $error("operand read outside phase two");

    AST_WRAP: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        ph_two |-> PROG_ADDR_OUT == $past(pc_reg[PROG_AW-1:0]))
        else $error("program address not wrapped");

    AST_INSN_Q1: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        ($changed(insn_reg) && $past(RESET_N_IN)) |-> $past(ph_one))
        else $error("instruction latch loaded outside phase one");

    AST_DEST_Q4: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        ($changed(status_reg) && $past(RESET_N_IN) && !$past(WR_STB_IN))
        |-> $past(ph_four))
        else $error("destination written outside phase four");

    AST_GPR_DEPTH: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        (sel[1].kind == DM_GPR) |-> (int'(sel[1].idx) < GPR_DEPTH))
        else $error("register file index beyond its depth");

    AST_SHARED_STATUS: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        (RD_STB_IN && ADDR_IN[6:0] == `FPM_ADDR_STATUS && !WR_STB_IN)
        |=> RD_DATA_OUT == $past(status_reg))
        else $error("status not shared by both banks");

    AST_RD_IDLE: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        !RD_STB_IN |=> RD_DATA_OUT == 8'h00)
        else $error("read data stands outside its cycle");

    COV_JUMP: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        jump_take);
    COV_INT: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        int_take);
    COV_PCL: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        pcl_load);
    COV_INDIRECT: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        RD_STB_IN && ADDR_IN[6:0] == `FPM_ADDR_INDIRECT
        && sel[1].kind == DM_GPR);
endmodule : fpm_core

// ---- fpm_pkg.sv ----
// types shared by the fetch pipeline block
package fpm_pkg;
    typedef enum logic [1:0] {
        PH_ONE   = 2'b00,
        PH_TWO   = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR  = 2'b11
    } fpm_phase_e;

    typedef enum logic [2:0] {
        DM_NONE   = 3'b000,
        DM_PCL    = 3'b001,
        DM_STATUS = 3'b010,
        DM_FSR    = 3'b011,
        DM_PC_HIGH_LATCH = 3'b100,
        DM_INTCTL = 3'b101,
        DM_GPR    = 3'b110
    } fpm_dm_kind_e;

    typedef struct packed {
        fpm_dm_kind_e kind;
        logic [6:0]   idx;
    } fpm_dm_sel_s;
endpackage : fpm_pkg
